// ===== core/imc_pkg.sv
// shared constants and types for the mode control block
package imc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0]  MODE_CONTROL_OFS   = 8'h24;   // mode control register
   localparam logic [7:0]  TRANSFER_COUNT_OFS = 8'h14;   // transfer count register

   // ****************************************
   // mode control field positions
   // ****************************************
   localparam int NOACK_BIT    = 15;                     // no-acknowledge request
   localparam int FREE_BIT     = 14;                     // emulation bit, no effect
   localparam int START_BIT    = 13;                     // start request
   localparam int STOP_BIT     = 11;                     // stop request
   localparam int MASTER_BIT   = 10;                     // master select
   localparam int TRANSMIT_BIT = 9;                      // transmit select
   localparam int REPEAT_BIT   = 7;                      // repeat mode select
   localparam int LOW_MSB      = 9;                      // top of plain low fields
   localparam int COUNT_W      = 16;                     // transfer count width
   localparam int CNT_W        = 17;                     // internal counter width

   // ****************************************
   // reset values and counts
   // ****************************************
   localparam logic [LOW_MSB:0]   LOW_RESET   = 10'h000;   // low fields after reset
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;  // transfer count after reset
   localparam logic [CNT_W-1:0]   CNT_FULL    = 17'h10000; // counter load for count zero
   localparam logic [CNT_W-1:0]   CNT_ONE     = 17'h00001; // last word still pending
   localparam logic [CNT_W-1:0]   CNT_ZERO    = 17'h00000; // counter exhausted
   localparam logic [31:0]        RDATA_NONE  = 32'h00000000; // unmapped read value

   // ****************************************
   // master sequence states, gray along the path
   // ****************************************
   typedef enum logic [1:0] {
      IMC_IDLE  = 2'b00,
      IMC_START = 2'b01,
      IMC_XFER  = 2'b11,
      IMC_STOP  = 2'b10
   } imc_state_t;

endpackage : imc_pkg

// ===== core/imc_mode_control.sv
// mode control register and start/stop/acknowledge sequencing of the i2c controller
// Operation
// - reserved bits read zero, writes ignored
// - slave receiver acknowledges unless nack requested
// - master receiver nacks when counter reaches zero
// - nack request sends nack, then self-clears
// - emulation bit stored but has no effect
// - start request makes start, then self-clears
// - slave without start request ignores bus
// - slave with start request serves master
// - stop request stops once counter is zero
// - stop request self-clears after stop done
// - repeat, start, stop bound master transfers
// - master select drops to slave on stop
// - count zero loads counter with 65536
// - repeat mode runs until stop request
//
// Design decision made here: strobed register access.
module imc_mode_control
   import imc_pkg::*;
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   // events from the bit engine
   input  wire logic                eng_start_done,
   input  wire logic                eng_stop_done,
   input  wire logic                eng_ack_slot,
   input  wire logic                eng_word_done,
   // commands to the bit engine
   output logic                     gen_start,
   output logic                     gen_stop,
   output logic                     ack_nack,
   output logic                     slave_listen,
   output logic                     master_mode,
   output logic                     transmit_mode
);
   import imc_pkg::*;

   // ****************************************
   // overview
   // ****************************************
   // software writes one-shot requests into the mode control register;
   // the sequence below turns them into start and stop commands for the
   // bit engine, which answers each with a done pulse. the engine also
   // reports the last data bit of each received byte (ack slot) and the
   // end of each word, from which the acknowledge level and the word
   // counter are kept.
   // limitation: the emulation bit is only stored; the block always runs
   // free, so a debugger halt never freezes a transfer half way.
   // trade-off: requests latch on a written one and are cleared only by
   // hardware (or by a slave dropping its start request), so a
   // read-modify-write never cancels a pending request.

   // ****************************************
   // reset release
   // ****************************************
   logic        rst_meta;                 // first release stage
   logic        rst_sync_n;               // released reset for the block

   // two stages so release never lands near a clock edge;
   // assertion stays asynchronous so a dead clock still clears the block,
   // release costs two cycles, which software never sees in practice
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ****************************************
   // state
   // ****************************************
   // software visible fields
   logic                 noack_request;     // one-shot nack request
   logic                 free_bit;          // emulation bit
   logic                 start_request;     // one-shot start request
   logic                 stop_request;      // stop request
   logic                 master_select;     // master when set
   logic [LOW_MSB:0]     low_fields;        // transmit, addressing, repeat, etc
   logic [COUNT_W-1:0]   transfer_count_value; // programmed word count
   // hidden sequencing state
   logic [CNT_W-1:0]     word_cnt;          // internal transfer counter
   imc_state_t           state;             // master sequence state

   // ****************************************
   // next values
   // ****************************************
   // register fields
   logic                 next_noack_request;        // nack request after this edge
   logic                 next_free_bit;             // emulation bit after this edge
   logic                 next_start_request;        // start request after this edge
   logic                 next_stop_request;         // stop request after this edge
   logic                 next_master_select;        // master select after this edge
   logic [LOW_MSB:0]     next_low_fields;           // low fields after this edge
   logic [COUNT_W-1:0]   next_transfer_count_value; // count after this edge
   // sequencing
   logic [CNT_W-1:0]     next_word_cnt;             // counter after this edge
   imc_state_t           next_state;                // state after this edge
   // outputs
   logic [31:0]          next_reg_rdata;            // read data for the next cycle
   logic                 next_gen_start;            // start command
   logic                 next_gen_stop;             // stop command
   logic                 next_ack_nack;             // acknowledge level
   logic                 next_slave_listen;         // slave serving the bus
   logic                 next_master_mode;          // master mode output
   logic                 next_transmit_mode;        // transmit mode output

   // ****************************************
   // address decode
   // ****************************************
   logic                 wr_mode;           // write hits mode control
   logic                 wr_count;          // write hits transfer count
   logic                 repeat_on;         // repeat mode selected
   logic                 last_word;         // this word empties the counter

   // the count register is only sampled at start, so a rewrite during a
   // transfer shapes the next transfer, never the running one
   assign wr_mode   = reg_wr && (reg_addr == MODE_CONTROL_OFS);
   assign wr_count  = reg_wr && (reg_addr == TRANSFER_COUNT_OFS);
   assign repeat_on = low_fields[REPEAT_BIT];
   assign last_word = (word_cnt == CNT_ONE) || (word_cnt == CNT_ZERO);

   // ****************************************
   // register and sequence next values
   // ****************************************
   // hardware clears are applied first, software writes after them,
   // so a set written in the same cycle as a clear is never lost
   always_comb begin
      next_noack_request        = noack_request;
      next_free_bit             = free_bit;
      next_start_request        = start_request;
      next_stop_request         = stop_request;
      next_master_select        = master_select;
      next_low_fields           = low_fields;
      next_transfer_count_value = transfer_count_value;
      next_word_cnt             = word_cnt;
      next_state                = state;
      next_ack_nack             = ack_nack;

      // words counted down only outside repeat mode; kept ahead of the
      // sequence so a counter load at start wins over a word ending then
      if (eng_word_done && !repeat_on && word_cnt != CNT_ZERO) begin
         next_word_cnt = word_cnt - CNT_ONE;
      end

      // sequence of one master transfer
      unique case (state)
         IMC_IDLE: begin
            // a slave never leaves idle, so it never drives a start
            if (master_select && start_request) begin
               next_state = IMC_START;
            end
         end
         IMC_START: begin
            if (eng_start_done) begin
               next_start_request = 1'b0;
               // zero count means the full 65536 words
               next_word_cnt = (transfer_count_value == COUNT_RESET) ?
                               CNT_FULL : {1'b0, transfer_count_value};
               next_state    = IMC_XFER;
            end
         end
         IMC_XFER: begin
            // repeat mode ignores the count and only stops on request
            if (stop_request && (repeat_on || word_cnt == CNT_ZERO)) begin
               next_state = IMC_STOP;
            end else if (start_request && repeat_on) begin
               next_state = IMC_START;
            end
         end
         IMC_STOP: begin
            // dropping master here hands the bus back to other masters
            if (eng_stop_done) begin
               next_stop_request  = 1'b0;
               next_master_select = 1'b0;
               next_state         = IMC_IDLE;
            end
         end
      endcase

      // acknowledge decision at the end of each received byte; the level is
      // held until the next slot, so the engine may sample it at any time
      // between the last data bit and the acknowledge clock
      if (eng_ack_slot) begin
         if (noack_request) begin
            next_ack_nack      = 1'b1;
            next_noack_request = 1'b0;
         end else if (master_select && !repeat_on && last_word) begin
            next_ack_nack = 1'b1;
         end else begin
            next_ack_nack = 1'b0;
         end
      end

      // software writes; request bits other than a slave's start request only latch on a one, so writing back
      // a value read earlier never cancels a request in flight
      if (wr_mode) begin
         if (reg_wdata[NOACK_BIT]) begin
            next_noack_request = 1'b1;
         end
         if (reg_wdata[START_BIT]) begin
            next_start_request = 1'b1;
         end else if (!master_select) begin
            next_start_request = 1'b0;
         end
         if (reg_wdata[STOP_BIT]) begin
            next_stop_request = 1'b1;
         end
         next_free_bit      = reg_wdata[FREE_BIT];
         // master select is plain; only a finished stop clears it by itself
         next_master_select = reg_wdata[MASTER_BIT];
         next_low_fields    = reg_wdata[LOW_MSB:0];
      end
      if (wr_count) begin
         next_transfer_count_value = reg_wdata[COUNT_W-1:0];
      end
   end

   // ****************************************
   // outputs to the bit engine
   // ****************************************
   // commands follow the next state so they rise with it, not a cycle later
   always_comb begin
      next_gen_start     = (next_state == IMC_START);
      next_gen_stop      = (next_state == IMC_STOP);
      // slave serves the bus only while start request is held
      next_slave_listen  = !next_master_select && next_start_request;
      next_master_mode   = next_master_select;
      next_transmit_mode = next_low_fields[TRANSMIT_BIT];
   end

   // ****************************************
   // read path
   // ****************************************
   // read data, one cycle after the strobe and only then
   // unmapped addresses and reserved bits fall through as zero
   always_comb begin
      next_reg_rdata = RDATA_NONE;
      if (reg_rd) begin
         if (reg_addr == MODE_CONTROL_OFS) begin
            next_reg_rdata[NOACK_BIT]  = noack_request;
            next_reg_rdata[FREE_BIT]   = free_bit;
            next_reg_rdata[START_BIT]  = start_request;
            next_reg_rdata[STOP_BIT]   = stop_request;
            next_reg_rdata[MASTER_BIT] = master_select;
            next_reg_rdata[LOW_MSB:0]  = low_fields;
         end else if (reg_addr == TRANSFER_COUNT_OFS) begin
            next_reg_rdata[COUNT_W-1:0] = transfer_count_value;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // plain register stage; all decisions live in the processes above
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         noack_request        <= 1'b0;
         free_bit             <= 1'b0;
         start_request        <= 1'b0;
         stop_request         <= 1'b0;
         master_select        <= 1'b0;
         low_fields           <= LOW_RESET;
         transfer_count_value <= COUNT_RESET;
         word_cnt             <= CNT_ZERO;
         state                <= IMC_IDLE;
         reg_rdata            <= RDATA_NONE;
         // outputs sit low in reset so the engine sees no command
         gen_start            <= 1'b0;
         gen_stop             <= 1'b0;
         ack_nack             <= 1'b0;
         slave_listen         <= 1'b0;
         master_mode          <= 1'b0;
         transmit_mode        <= 1'b0;
      end else begin
         noack_request        <= next_noack_request;
         free_bit             <= next_free_bit;
         start_request        <= next_start_request;
         stop_request         <= next_stop_request;
         master_select        <= next_master_select;
         low_fields           <= next_low_fields;
         transfer_count_value <= next_transfer_count_value;
         word_cnt             <= next_word_cnt;
         state                <= next_state;
         reg_rdata            <= next_reg_rdata;
         gen_start            <= next_gen_start;
         gen_stop             <= next_gen_stop;
         ack_nack             <= next_ack_nack;
         slave_listen         <= next_slave_listen;
         master_mode          <= next_master_mode;
         transmit_mode        <= next_transmit_mode;
      end
   end

endmodule : imc_mode_control

// ===== test/imc_mode_control_monitor.sv
// assertion checker for the mode control block
module imc_mc_monitor (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // engine link
   input wire logic        eng_start_done,
   input wire logic        eng_stop_done,
   input wire logic        eng_ack_slot,
   input wire logic        gen_start,
   input wire logic        gen_stop,
   input wire logic        ack_nack,
   input wire logic        slave_listen,
   input wire logic        master_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // sequences and properties
   // ****************************************
   // nack request written, then the ack slot three edges later
   sequence s_nack_set;
      reg_wr && reg_addr == 8'h24 && reg_wdata[15] ##1 !eng_ack_slot [*2] ##1 eng_ack_slot;
   endsequence
   property p_nack_sent; s_nack_set |=> ack_nack; endproperty
   property p_ack_hold; !eng_ack_slot |=> $stable(ack_nack); endproperty
   property p_start_rise;
      reg_wr && reg_addr == 8'h24 && reg_wdata[13] && reg_wdata[10] && !master_mode
         && !gen_start |-> ##2 gen_start;
   endproperty
   property p_start_clear; gen_start && eng_start_done |=> !gen_start; endproperty
   property p_start_master; gen_start |-> master_mode; endproperty
   property p_stop_clear; gen_stop && eng_stop_done |=> !gen_stop && !master_mode; endproperty
   property p_stop_master; gen_stop |-> master_mode; endproperty
   property p_listen_slave; slave_listen |-> !master_mode; endproperty
   property p_listen_write;
      reg_wr && reg_addr == 8'h24 && !reg_wdata[10] && !master_mode
         |=> slave_listen == $past(reg_wdata[13]);
   endproperty
   property p_reserved; reg_rd && reg_addr == 8'h24 |=> reg_rdata[31:16] == 16'h0000
      && !reg_rdata[12]; endproperty
   property p_unmapped; reg_rd && reg_addr != 8'h24 && reg_addr != 8'h14
      |=> reg_rdata == 32'h00000000; endproperty
   // ****************************************
   // assertions
   // ****************************************
   a_nack_sent: assert property (p_nack_sent) else $error("nack not driven");
   a_ack_hold: assert property (p_ack_hold) else $error("ack moved off slot");
   a_start_rise: assert property (p_start_rise) else $error("start missing");
   a_start_clear: assert property (p_start_clear) else $error("start stuck");
   a_start_master: assert property (p_start_master) else $error("slave start");
   a_stop_clear: assert property (p_stop_clear) else $error("stop stuck");
   a_stop_master: assert property (p_stop_master) else $error("stop as slave");
   a_listen_slave: assert property (p_listen_slave) else $error("listen as master");
   a_listen_write: assert property (p_listen_write) else $error("listen off request");
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
endmodule : imc_mc_monitor

bind imc_mode_control imc_mc_monitor u_mon (.core_clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .eng_start_done, .eng_stop_done, .eng_ack_slot,
   .gen_start, .gen_stop, .ack_nack, .slave_listen, .master_mode);

// ===== test/imc_engine_model.sv
// behavioural bit engine answering start, stop and byte requests
module imc_engine_model (
   // clock
   input  wire logic core_clk,
   // commands from the block
   input  wire logic gen_start,
   input  wire logic gen_stop,
   // bench controls
   input  wire logic byte_go,
   input  wire logic slow,
   // events to the block
   output logic      eng_start_done = 1'b0,
   output logic      eng_stop_done = 1'b0,
   output logic      eng_ack_slot = 1'b0,
   output logic      eng_word_done = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_cnt = 0;  // cycles spent on the bus condition
   // one pulse per command; skip the edge where the block still sees our pulse
   always @(posedge core_clk) begin
      eng_start_done <= 1'b0;
      eng_stop_done  <= 1'b0;
      eng_ack_slot   <= byte_go;       // last data bit of a byte
      eng_word_done  <= eng_ack_slot;  // word closes after its ack slot
      if ((gen_start || gen_stop) && !eng_start_done && !eng_stop_done) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= (slow ? 4 : 1)) begin
            eng_start_done <= gen_start;
            eng_stop_done  <= !gen_start;
            wait_cnt       <= 0;
         end
      end
   end
endmodule : imc_engine_model

// ===== test/tb.sv
// self-checking bench for the mode control block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        byte_go = 1'b0;  // ask the engine for one byte
   logic        slow = 1'b0;     // engine answers late
   logic [31:0] reg_rdata;
   logic        eng_start_done, eng_stop_done, eng_ack_slot, eng_word_done;
   logic        gen_start, gen_stop, ack_nack, slave_listen, master_mode, transmit_mode;
   int          n_fail = 0;
   int          comparisons = 0;
   int          cycles = 0;
   imc_mode_control u_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .eng_start_done, .eng_stop_done, .eng_ack_slot, .eng_word_done,
      .gen_start, .gen_stop, .ack_nack, .slave_listen, .master_mode, .transmit_mode);
   imc_engine_model u_eng (.core_clk, .gen_start, .gen_stop, .byte_go, .slow,
      .eng_start_done, .eng_stop_done, .eng_ack_slot, .eng_word_done);
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, reg_rdata, exp);
   endtask : rd
   task automatic byte_rx;
      @(posedge core_clk);
      byte_go <= 1'b1;
      @(posedge core_clk);
      byte_go <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : byte_rx
   // long enough for the slow engine to answer a condition
   task automatic settle;
      repeat (12) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // hang guard, tests need under two hundred cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up;
      end
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(8'h24, 32'h0, "mode reset");
      rd(8'h14, 32'h0, "count reset");
      rd(8'h30, 32'h0, "unmapped");
      wr(8'h24, 32'hffff5200);
      rd(8'h24, 32'h00004200, "reserved");
      chk("transmit", 32'(transmit_mode), 32'h1);
      wr(8'h24, 32'h0);
      $display("test registers done");
      wr(8'h24, 32'h2000);
      settle;
      chk("listen", 32'(slave_listen), 32'h1);
      chk("slave start", 32'(gen_start), 32'h0);
      byte_rx;
      chk("slave ack", 32'(ack_nack), 32'h0);
      wr(8'h24, 32'ha000);
      byte_rx;
      chk("slave nack", 32'(ack_nack), 32'h1);
      rd(8'h24, 32'h2000, "nack clear");
      byte_rx;
      chk("ack again", 32'(ack_nack), 32'h0);
      wr(8'h24, 32'h0);
      settle;
      chk("deaf", 32'(slave_listen), 32'h0);
      $display("test slave done");
      wr(8'h14, 32'hffff0002);
      rd(8'h14, 32'h00000002, "count write");
      wr(8'h24, 32'h2c00);
      @(posedge core_clk);
      #1 chk("start", 32'(gen_start), 32'h1);
      chk("master on", 32'(master_mode), 32'h1);
      settle;
      rd(8'h24, 32'h0c00, "start clear");
      byte_rx;
      chk("master ack", 32'(ack_nack), 32'h0);
      chk("early stop", 32'(gen_stop), 32'h0);
      byte_rx;
      chk("last nack", 32'(ack_nack), 32'h1);
      settle;
      chk("stop gone", 32'(gen_stop), 32'h0);
      rd(8'h24, 32'h0, "stop done");
      chk("master off", 32'(master_mode), 32'h0);
      $display("test master count done");
      @(posedge core_clk);
      slow <= 1'b1;
      wr(8'h14, 32'h0);
      wr(8'h24, 32'h2400);
      settle;
      byte_rx;
      chk("count zero", 32'(ack_nack), 32'h0);
      wr(8'h24, 32'h0480);
      byte_rx;
      byte_rx;
      chk("repeat ack", 32'(ack_nack), 32'h0);
      chk("repeat run", 32'(gen_stop), 32'h0);
      wr(8'h24, 32'h0c80);
      @(posedge core_clk);
      #1 chk("repeat stop", 32'(gen_stop), 32'h1);
      settle;
      rd(8'h24, 32'h0080, "repeat end");
      $display("test repeat done");
      wrap_up;
   end
endmodule : tb
